// *** logic/bridge_config_header_regs.sv ***
// Configuration header register bank behind a classic Wishbone slave
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module bridge_config_header_regs
  import bridge_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [31:0] io_window_base_o,
  output logic [31:0] memory_window_base_o,
  output logic [7:0] irq_routing_line_o
);

  // ****************************************
  // Bus handshake
  // ****************************************
  logic ack_ff;
  logic req;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;

  // One wait state; ack falls the cycle after it rises
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_go = req & wb_we_i;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  // ****************************************
  // Address decode
  // ****************************************
  logic hit_class;
  logic hit_misc;
  logic hit_io_base;
  logic hit_mem_base;
  logic hit_subsys;
  logic hit_cap_ptr;
  logic hit_irq;
  logic hit_pm_cap;
  logic hit_load_subsys;
  logic hit_load_misc;

  logic wr_misc;
  logic wr_io_base;
  logic wr_mem_base;
  logic wr_irq;
  logic wr_load_subsys;
  logic wr_load_misc;
  logic rd_go;
  logic [3:0] wr_load_lane;

  // Full byte-address compare, so a misaligned address hits nothing
  assign hit_class = (wb_adr_i == OFS_CLASS);
  assign hit_misc = (wb_adr_i == OFS_MISC);
  assign hit_io_base = (wb_adr_i == OFS_IO_BASE);
  assign hit_mem_base = (wb_adr_i == OFS_MEM_BASE);
  assign hit_subsys = (wb_adr_i == OFS_SUBSYS);
  assign hit_cap_ptr = (wb_adr_i == OFS_CAP_PTR);
  assign hit_irq = (wb_adr_i == OFS_IRQ);
  assign hit_pm_cap = (wb_adr_i == OFS_PM_CAP);
  assign hit_load_subsys = (wb_adr_i == OFS_LOAD_SUBSYS);
  assign hit_load_misc = (wb_adr_i == OFS_LOAD_MISC);

  // Read-only words get no write strobe, so host writes there are lost
  assign wr_misc = wr_go & hit_misc;
  assign wr_io_base = wr_go & hit_io_base;
  assign wr_mem_base = wr_go & hit_mem_base;
  assign wr_irq = wr_go & hit_irq;
  assign wr_load_subsys = wr_go & hit_load_subsys;
  assign wr_load_misc = wr_go & hit_load_misc;
  assign rd_go = req & ~wb_we_i;

  // Byte strobes of the load window word at C4h
  generate
    for (g = 0; g < 4; g++) begin : g_load_lane
      assign wr_load_lane[g] = wr_load_misc & wb_sel_i[g];
    end
  endgenerate

  // ****************************************
  // Writable header fields
  // ****************************************
  logic [7:0] cache_line_ff;
  logic [7:0] irq_line_ff;
  logic [7:0] io_lane_ff [4];
  logic [7:0] mem_lane_ff [4];
  logic [31:0] io_base;
  logic [31:0] mem_base;

  // Stored but unused by the block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cache_line_ff <= RST_CACHE_LINE;
    end else if (wr_misc && wb_sel_i[0]) begin
      cache_line_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_line_ff <= RST_IRQ_LINE;
    end else if (wr_irq && wb_sel_i[0]) begin
      irq_line_ff <= wb_dat_i[7:0];
    end
  end

  // Low bits below the window size never take write data; sizing relies on it
  generate
    for (g = 0; g < 4; g++) begin : g_io_lane
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          io_lane_ff[g] <= RST_IO_BASE[g*8 +: 8];
        end else if (wr_io_base && wb_sel_i[g]) begin
          io_lane_ff[g] <= (io_lane_ff[g] & ~IO_BASE_MASK[g*8 +: 8])
                         | (wb_dat_i[g*8 +: 8] & IO_BASE_MASK[g*8 +: 8]);
        end
      end
      assign io_base[g*8 +: 8] = io_lane_ff[g];
    end
  endgenerate

  generate
    for (g = 0; g < 4; g++) begin : g_mem_lane
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mem_lane_ff[g] <= RST_MEM_BASE[g*8 +: 8];
        end else if (wr_mem_base && wb_sel_i[g]) begin
          mem_lane_ff[g] <= (mem_lane_ff[g] & ~MEM_BASE_MASK[g*8 +: 8])
                          | (wb_dat_i[g*8 +: 8] & MEM_BASE_MASK[g*8 +: 8]);
        end
      end
      assign mem_base[g*8 +: 8] = mem_lane_ff[g];
    end
  endgenerate

  // ****************************************
  // Auto-load staging (stands in for the EEPROM loader)
  // ****************************************
  // Host-side RO views never accept writes; only the load window does
  logic [15:0] sub_maker_ff;
  logic [15:0] sub_device_ff;
  logic [7:0] cap_ptr_ff;
  logic dev_init_ff;
  logic [2:0] aux_current_ff;
  logic d1_support_ff;
  logic d2_support_ff;
  logic [4:0] pme_support_ff;
  load_fields_s load_view;

  // Subsystem codes take bytes lane by lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_maker_ff <= DEF_SUB_MAKER;
    end else if (wr_load_subsys) begin
      sub_maker_ff <= (sub_maker_ff & ~wmask[15:0])
                    | (wb_dat_i[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_device_ff <= DEF_SUB_DEVICE;
    end else if (wr_load_subsys) begin
      sub_device_ff <= (sub_device_ff & ~wmask[31:16])
                     | (wb_dat_i[31:16] & wmask[31:16]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_ptr_ff <= DEF_CAP_PTR;
    end else if (wr_load_lane[0]) begin
      cap_ptr_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_init_ff <= DEF_DEV_INIT;
    end else if (wr_load_lane[2]) begin
      dev_init_ff <= wb_dat_i[21];
    end
  end

  // Auxiliary current straddles lanes 2 and 3
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_current_ff <= DEF_AUX_CURRENT;
    end else begin
      if (wr_load_lane[2]) begin
        aux_current_ff[1:0] <= wb_dat_i[23:22];
      end
      if (wr_load_lane[3]) begin
        aux_current_ff[2] <= wb_dat_i[24];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      d1_support_ff <= DEF_D1_SUPPORT;
    end else if (wr_load_lane[3]) begin
      d1_support_ff <= wb_dat_i[25];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      d2_support_ff <= DEF_D2_SUPPORT;
    end else if (wr_load_lane[3]) begin
      d2_support_ff <= wb_dat_i[26];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pme_support_ff <= DEF_PME_SUPPORT;
    end else if (wr_load_lane[3]) begin
      pme_support_ff <= wb_dat_i[31:27];
    end
  end

  // Gathered view of everything the loader may replace
  assign load_view = '{
    sub_device: sub_device_ff,
    sub_maker: sub_maker_ff,
    cap_ptr: cap_ptr_ff,
    pme_support: pme_support_ff,
    d2_support: d2_support_ff,
    d1_support: d1_support_ff,
    aux_current: aux_current_ff,
    dev_init: dev_init_ff
  };

  // ****************************************
  // Power capability word
  // ****************************************
  logic [15:0] pm_caps;
  // Bits 16 to 20 are fixed; the rest follow the loader
  assign pm_caps = {load_view.pme_support,
                    load_view.d2_support,
                    load_view.d1_support,
                    load_view.aux_current,
                    load_view.dev_init,
                    AUX_POWER_VAL,
                    PME_CLOCK_VAL,
                    PM_REVISION};

  // ****************************************
  // Read words
  // ****************************************
  logic [31:0] word_class;
  logic [31:0] word_misc;
  logic [31:0] word_io;
  logic [31:0] word_mem;
  logic [31:0] word_subsys;
  logic [31:0] word_cap_ptr;
  logic [31:0] word_irq;
  logic [31:0] word_pm_cap;
  logic [31:0] word_load_subsys;
  logic [31:0] word_load_misc;

  assign word_class = {BASE_CLASS, SUB_CLASS, PROG_IF, 8'h00};
  assign word_misc = {8'h00, LAYOUT_VAL, LATENCY_VAL, cache_line_ff};
  assign word_io = io_base;
  assign word_mem = mem_base;
  assign word_subsys = {load_view.sub_device, load_view.sub_maker};
  assign word_cap_ptr = {24'h00_0000, load_view.cap_ptr};
  assign word_irq = {16'h0000, IRQ_PIN_VAL, irq_line_ff};
  assign word_pm_cap = {pm_caps, PM_NEXT_PTR, PM_CAP_ID};
  assign word_load_subsys = {sub_device_ff, sub_maker_ff};
  // The load window reads back its own layout, bits 15:8 unused
  assign word_load_misc = {pm_caps, 8'h00, load_view.cap_ptr};

  // Unmapped words read as zero
  always_comb begin
    nxt_dat = 32'h0000_0000;
    if (hit_class) begin
      nxt_dat = word_class;
    end else if (hit_misc) begin
      nxt_dat = word_misc;
    end else if (hit_io_base) begin
      nxt_dat = word_io;
    end else if (hit_mem_base) begin
      nxt_dat = word_mem;
    end else if (hit_subsys) begin
      nxt_dat = word_subsys;
    end else if (hit_cap_ptr) begin
      nxt_dat = word_cap_ptr;
    end else if (hit_irq) begin
      nxt_dat = word_irq;
    end else if (hit_pm_cap) begin
      nxt_dat = word_pm_cap;
    end else if (hit_load_subsys) begin
      nxt_dat = word_load_subsys;
    end else if (hit_load_misc) begin
      nxt_dat = word_load_misc;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read data registered with ack; a write leaves the last read value standing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      dat_ff <= nxt_dat;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Registered copies for the address decoders downstream
  assign io_window_base_o = io_base;
  assign memory_window_base_o = mem_base;
  assign irq_routing_line_o = irq_line_ff;

endmodule // bridge_config_header_regs

// *** common/bridge_cfg_pkg.sv ***
// Constants, layouts and types for the bridge configuration header register bank
// Overview of operation
// - Class code reads 07h, 00h, 02h
// - Cache line size writable, resets 00h, unused
// - Latency timer hardwired to zero
// - Header type reads 00h
// - I/O window base, 64 bytes, reset 1
// - Memory window base, 4096 bytes, reset 0
// - Subsystem maker and device codes, loadable
// - Capability list start 80h, loadable
// - Interrupt routing line writable, resets 00h
// - Interrupt pin reads 01h
// - Power capability identifier reads 01h
// - Next capability link reads 8Ch
// - Power management revision reads 011b
// - Event clock bit hardwired zero
// - Auxiliary power bit reads one
// - Device-specific init bit 0, loadable
// - Auxiliary current 111b, loadable
// - Wake-event support 01000b, loadable
package bridge_cfg_pkg;

  // ****************************************
  // Register word offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CLASS = 8'h08;
  localparam logic [7:0] OFS_MISC = 8'h0c;
  localparam logic [7:0] OFS_IO_BASE = 8'h10;
  localparam logic [7:0] OFS_MEM_BASE = 8'h14;
  localparam logic [7:0] OFS_SUBSYS = 8'h2c;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_IRQ = 8'h3c;
  localparam logic [7:0] OFS_PM_CAP = 8'h80;
  localparam logic [7:0] OFS_LOAD_SUBSYS = 8'hc0;
  localparam logic [7:0] OFS_LOAD_MISC = 8'hc4;

  // ****************************************
  // Fixed values
  // ****************************************
  localparam logic [7:0] BASE_CLASS = 8'h07;
  localparam logic [7:0] SUB_CLASS = 8'h00;
  localparam logic [7:0] PROG_IF = 8'h02;
  localparam logic [7:0] LATENCY_VAL = 8'h00;
  localparam logic [7:0] LAYOUT_VAL = 8'h00;
  localparam logic [7:0] IRQ_PIN_VAL = 8'h01;
  localparam logic [7:0] PM_CAP_ID = 8'h01;
  localparam logic [7:0] PM_NEXT_PTR = 8'h8c;
  localparam logic [2:0] PM_REVISION = 3'h3;
  localparam logic PME_CLOCK_VAL = 1'b0;
  localparam logic AUX_POWER_VAL = 1'b1;

  // ****************************************
  // Reset values and defaults
  // ****************************************
  localparam logic [7:0] RST_CACHE_LINE = 8'h00;
  localparam logic [7:0] RST_IRQ_LINE = 8'h00;
  localparam logic [31:0] RST_IO_BASE = 32'h0000_0001;
  localparam logic [31:0] RST_MEM_BASE = 32'h0000_0000;
  // Subsystem codes are arbitrary neutral values
  localparam logic [15:0] DEF_SUB_MAKER = 16'h1a2b;
  localparam logic [15:0] DEF_SUB_DEVICE = 16'h3c4d;
  localparam logic [7:0] DEF_CAP_PTR = 8'h80;
  localparam logic DEF_DEV_INIT = 1'b0;
  localparam logic [2:0] DEF_AUX_CURRENT = 3'h7;
  localparam logic DEF_D1_SUPPORT = 1'b1;
  localparam logic DEF_D2_SUPPORT = 1'b1;
  localparam logic [4:0] DEF_PME_SUPPORT = 5'h08;

  // ****************************************
  // Window base field layout
  // ****************************************
  localparam int IO_WIN_BITS = 6;
  localparam int MEM_WIN_BITS = 12;
  localparam logic [31:0] IO_BASE_MASK = 32'hffff_ffc0;
  localparam logic [31:0] MEM_BASE_MASK = 32'hffff_f000;

  // Auto-loadable fields gathered together
  typedef struct packed {
    logic [15:0] sub_device;
    logic [15:0] sub_maker;
    logic [7:0] cap_ptr;
    logic [4:0] pme_support;
    logic d2_support;
    logic d1_support;
    logic [2:0] aux_current;
    logic dev_init;
  } load_fields_s;

  localparam load_fields_s LOAD_DEFAULT = '{
    sub_device: DEF_SUB_DEVICE,
    sub_maker: DEF_SUB_MAKER,
    cap_ptr: DEF_CAP_PTR,
    pme_support: DEF_PME_SUPPORT,
    d2_support: DEF_D2_SUPPORT,
    d1_support: DEF_D1_SUPPORT,
    aux_current: DEF_AUX_CURRENT,
    dev_init: DEF_DEV_INIT
  };

endpackage

// *** verification/cfg_checker_assertions.sv ***
// Checker for the config bank bus timing and window outputs
`timescale 1ns/1ps
module cfg_checker
  import bridge_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] io_window_base_o,
  input wire logic [31:0] memory_window_base_o,
  input wire logic [7:0] irq_routing_line_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd;
  logic wr;
  assign rd = wb_ack_o && !wb_we_i;
  assign wr = wb_ack_o && wb_we_i && (&wb_sel_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_reset_values: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && io_window_base_o == 32'h1 && memory_window_base_o == 0
      && irq_routing_line_o == 0) else $error("bad reset state");
  a_window_low: assert property (
    io_window_base_o[5:0] == 6'h01 && memory_window_base_o[11:0] == 0) else $error("low bits");
  a_io_write: assert property (
    wr && wb_adr_i == 8'h10 |=> io_window_base_o == ($past(wb_dat_i) & 32'hffff_ffc0 | 1))
    else $error("io base write");
  a_irq_write: assert property (
    wr && wb_adr_i == 8'h3c |=> irq_routing_line_o == $past(wb_dat_i[7:0]))
    else $error("irq write");
  a_class_read: assert property (
    rd && wb_adr_i == 8'h08 |-> wb_dat_o[31:8] == 24'h070002) else $error("class code");
  a_misc_read: assert property (
    rd && wb_adr_i == 8'h0c |-> wb_dat_o[23:8] == 0) else $error("misc word");
endmodule // cfg_checker

// *** verification/cfg_host.sv ***
// Host-side master on the classic register bus
`timescale 1ns/1ps
module cfg_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] v, output logic [31:0] r, output logic ok);
    ok = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, v};
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_i);
      ok = ack_i;
    end
    r = dat_i;
    // Released address and data lines show junk so stale values are never trusted
    {cyc_o, stb_o, adr_o, dat_o} <= {2'b00, ~a, ~v};
  endtask
endmodule // cfg_host

// *** verification/testbench.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module testbench;
  import bridge_cfg_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, ok;
  logic [7:0] adr, irq_o;
  logic [3:0] sel;
  logic [31:0] wd, rdat, io_o, mem_o, rd;
  int err_count = 0, n_tests = 0, seed = 32'h38a6;
  int cls, io, mem, irq, ld0, ld4, d, s;
  logic [7:0] adrs [11] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h2c, 8'h34, 8'h3c, 8'h80,
                            8'hc0, 8'hc4, 8'h40};
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  bridge_config_header_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .io_window_base_o(io_o), .memory_window_base_o(mem_o),
    .irq_routing_line_o(irq_o));
  cfg_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  function automatic int mrg(int o, int n, logic [3:0] m);
    for (int i = 0; i < 4; i++)
      if (m[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction
  function automatic int exp_rd(logic [7:0] a);
    case (a)
      8'h08: return 32'h0700_0200;
      8'h0c: return cls;
      8'h10: return io;
      8'h14: return mem;
      8'h2c, 8'hc0: return ld0;
      8'h34: return ld4 & 32'hff;
      8'h3c: return 32'h100 | irq;
      8'h80: return ld4 & 32'hffe0_0000 | 32'h0013_8c01;
      8'hc4: return ld4 | 32'h0013_0000;
      default: return 0;
    endcase
  endfunction
  function automatic void mwr(logic [7:0] a, int v, logic [3:0] m);
    case (a)
      8'h0c: cls = mrg(cls, v, m) & 32'hff;
      8'h10: io = mrg(io, v, m) & 32'hffff_ffc0 | 1;
      8'h14: mem = mrg(mem, v, m) & 32'hffff_f000;
      8'h3c: irq = mrg(irq, v, m) & 32'hff;
      8'hc0: ld0 = mrg(ld0, v, m);
      8'hc4: ld4 = mrg(ld4, v, m) & 32'hffe0_00ff;
      default: ;
    endcase
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, int e, logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic do_reset();
    rst_i <= 1;
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    {cls, mem, irq} = '0;
    io = 1;
    ld0 = {DEF_SUB_DEVICE, DEF_SUB_MAKER};
    ld4 = 32'h47c0_0080;
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [3:0] m, int v);
    host.xfer(w, a, m, v, rd, ok);
    if (!ok) begin
      chk("bus ack", 1, 0);
      test_done();
    end
    if (w)
      mwr(a, v, m);
    else
      chk($sformatf("word %h", a), exp_rd(a), rd);
  endtask
  task automatic sweep(string n);
    foreach (adrs[i]) acc(0, adrs[i], 4'hf, 0);
    chk("io base", io, io_o);
    chk("mem base", mem, mem_o);
    chk("irq line", irq, {24'h0, irq_o});
    $display("test %s done", n);
  endtask
  initial begin
    rst_i = 1;
    do_reset();
    sweep("reset values");
    acc(1, 8'h10, 4'hf, -1);
    acc(1, 8'h14, 4'hf, -1);
    sweep("window sizing");
    repeat (6) begin
      repeat (12) begin
        d = $random(seed);
        s = $random(seed);
        acc(1, adrs[{$random(seed)} % 11], s[3:0], d);
      end
      sweep("random writes");
    end
    do_reset();
    sweep("second reset");
    test_done();
  end
endmodule // testbench
bind bridge_config_header_regs cfg_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .io_window_base_o(io_window_base_o), .memory_window_base_o(memory_window_base_o),
  .irq_routing_line_o(irq_routing_line_o));
